// ===== dac_link_pkg.sv
// Shared constants and types for the converter serial link and update control.
package dac_link_pkg;

  // ==========================================================================
  // Frame and data layout
  // ==========================================================================
  localparam int unsigned FRAME_BITS     = 24;
  localparam int unsigned CODE_BITS      = 16;
  localparam int unsigned COUNT_BITS     = 5;
  localparam logic [4:0]  LAST_EDGE      = 5'h18;
  localparam logic [15:0] CODE_ZERO      = 16'h0000;
  localparam logic [15:0] CODE_MIDSCALE  = 16'h8000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLOCK_MHZ      = 200;
  // Bench-made serial clock period, in ns; the host end makes its own.
  localparam int unsigned LINK_PERIOD_NS = 64;
  // Busy assertion time after the frame, in ns.
  localparam int unsigned BUSY_HOLD_NS   = 100;
  localparam int unsigned BUSY_HOLD_CYC  = (BUSY_HOLD_NS * CLOCK_MHZ + 999) / 1000;
  // Host serial clock half period, in ns (about 7.7 MHz with readback).
  localparam int unsigned HALF_PERIOD_NS = 65;
  localparam int unsigned HALF_CYC       = (HALF_PERIOD_NS * CLOCK_MHZ + 999) / 1000;
  localparam logic [7:0]  BUSY_HOLD_CNT  = 8'(BUSY_HOLD_CYC);
  localparam logic [7:0]  HALF_CNT       = 8'(HALF_CYC);
  // Edges the converter end stays in reset after release, while its synchronisers fill.
  localparam logic [1:0]  SETTLE_CNT     = 2'h3;

  typedef enum logic [1:0] {
    host_idle,
    host_low,
    host_high,
    host_end
  } host_state_t;

endpackage : dac_link_pkg

// ===== dac_link_if.sv
// Interface carrying the serial link and the open-drain busy wire.
`timescale 1ns/10ps
interface dac_link_if;
  logic select_n;
  logic serial_clock;
  logic data_in;
  logic data_out;
  logic data_out_en;
  logic ready_n;
  logic load_output_n;
  logic busy_dev_oe;
  logic busy_host_oe;
  wire  busy_n = ~(busy_dev_oe | busy_host_oe);

  modport device (
    input  select_n,
    input  serial_clock,
    input  data_in,
    output data_out,
    output data_out_en,
    output ready_n,
    input  load_output_n,
    output busy_dev_oe,
    input  busy_n
  );

  modport host (
    output select_n,
    output serial_clock,
    output data_in,
    input  data_out,
    input  data_out_en,
    input  ready_n,
    output load_output_n,
    output busy_host_oe,
    input  busy_n
  );
endinterface : dac_link_if

// ===== sync2.sv
// Two-flop synchroniser for one level from outside the clock domain.
`timescale 1ns/10ps
module sync2 #(
  parameter logic INIT = 1'b1
) (
  input  wire logic clock,
  input  wire logic resetn,
  input  wire logic async_in,
  output logic      sync_out
);
  logic first;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      first    <= INIT;
      sync_out <= INIT;
    end else begin
      first    <= async_in;
      sync_out <= first;
    end
  end
endmodule : sync2

// ===== dac_device_end.sv
// Converter end: serial frame capture, readback, ready, busy and load control.
`timescale 1ns/10ps
module dac_device_end
  import dac_link_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        reset_level_mid,
  input  wire logic        soft_reset,
  dac_link_if.device       link,
  output logic [15:0]      output_code,
  output logic [15:0]      input_code,
  output logic             output_update
);
  // ==========================================================================
  // Synchronisers
  // ==========================================================================
  logic sel_n_s;
  logic sclk_s;
  logic din_s;
  logic load_n_s;
  logic busy_n_s;
  logic mid_s;

  sync2 #(.INIT(1'b1)) u_sel  (.clock(clock), .resetn(resetn), .async_in(link.select_n),      .sync_out(sel_n_s));
  sync2 #(.INIT(1'b0)) u_sclk (.clock(clock), .resetn(resetn), .async_in(link.serial_clock),  .sync_out(sclk_s));
  sync2 #(.INIT(1'b0)) u_din  (.clock(clock), .resetn(resetn), .async_in(link.data_in),       .sync_out(din_s));
  sync2 #(.INIT(1'b1)) u_load (.clock(clock), .resetn(resetn), .async_in(link.load_output_n), .sync_out(load_n_s));
  sync2 #(.INIT(1'b1)) u_busy (.clock(clock), .resetn(resetn), .async_in(link.busy_n),        .sync_out(busy_n_s));
  sync2 #(.INIT(1'b0)) u_mid  (.clock(clock), .resetn(resetn), .async_in(reset_level_mid),    .sync_out(mid_s));

  // ==========================================================================
  // Edge detection
  // ==========================================================================
  logic sel_n_d;
  logic sclk_d;
  logic load_n_d;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sel_n_d  <= 1'b1;
      sclk_d   <= 1'b0;
      load_n_d <= 1'b1;
    end else begin
      sel_n_d  <= sel_n_s;
      sclk_d   <= sclk_s;
      load_n_d <= load_n_s;
    end
  end

  wire sel_fall  = sel_n_d & ~sel_n_s;
  wire sel_rise  = ~sel_n_d & sel_n_s;
  wire sclk_rise = ~sclk_d & sclk_s;
  wire sclk_fall = sclk_d & ~sclk_s;
  wire load_fall = load_n_d & ~load_n_s;

  // ==========================================================================
  // Reset stretch
  // ==========================================================================
  // The synchronisers need two edges after a hardware reset before the level
  // select and the load strobe can be trusted, so the reset state is held
  // until they have settled; a strobe left low across reset is then dropped.
  logic [1:0] settle;
  logic       in_reset;

  wire settling = (settle != 2'h0);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      settle   <= SETTLE_CNT;
      in_reset <= 1'b1;
    end else begin
      settle   <= settling ? settle - 2'h1 : settle;
      in_reset <= soft_reset | settling;
    end
  end

  // ==========================================================================
  // Serial frame
  // ==========================================================================
  logic [4:0]  edge_count;
  logic [23:0] shift_in;
  logic        frame_done;
  logic        out_enable;
  logic        out_bit;

  // The 24th fall completes a frame; a shorter frame never reaches it.
  wire last_fall  = sclk_fall & ~sel_n_s & (edge_count == LAST_EDGE - 5'h01);
  wire [23:0] next_shift = {shift_in[22:0], din_s};

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      edge_count <= '0;
      shift_in   <= '0;
      frame_done <= 1'b0;
      out_enable <= 1'b0;
      out_bit    <= 1'b0;
      input_code <= CODE_ZERO;
    end else begin
      if (sel_fall) begin
        edge_count <= '0;
        out_enable <= 1'b1;
        out_bit    <= output_code[15];
      end else if (sel_rise) begin
        edge_count <= '0;
        frame_done <= 1'b0;
        out_enable <= 1'b0;
      end else if (!sel_n_s && sclk_fall && edge_count < LAST_EDGE) begin
        shift_in   <= next_shift;
        edge_count <= edge_count + 5'h01;
        if (last_fall) begin
          frame_done <= 1'b1;
          out_enable <= 1'b0;
          input_code <= next_shift[15:0];
        end
      end else if (!sel_n_s && sclk_rise && edge_count < LAST_EDGE) begin
        out_bit <= output_code[4'hf - edge_count[3:0]];
      end
      if (in_reset) begin
        input_code <= mid_s ? CODE_MIDSCALE : CODE_ZERO;
      end
    end
  end

  assign link.ready_n     = ~frame_done;
  assign link.data_out    = out_bit;
  assign link.data_out_en = out_enable;

  // ==========================================================================
  // Busy and load control
  // ==========================================================================
  logic [7:0] busy_count;
  logic       load_pending;
  logic       next_pending;

  wire own_busy   = (busy_count != 8'h00) | in_reset;
  wire line_busy  = ~busy_n_s;
  // The wire comes back two edges late, so our own busy gates the load as well.
  wire blocked    = own_busy | line_busy;
  wire load_take  = load_fall & ~in_reset;
  wire load_now   = (load_take | load_pending) & ~blocked;

  always_comb begin
    next_pending = load_pending;
    if (in_reset) begin
      next_pending = 1'b0;
    end else if (load_now) begin
      next_pending = 1'b0;
    end else if (load_take) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_count <= '0;
    end else if (last_fall) begin
      busy_count <= BUSY_HOLD_CNT;
    end else if (busy_count != 8'h00) begin
      busy_count <= busy_count - 8'h01;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      load_pending <= 1'b0;
    end else begin
      load_pending <= next_pending;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      output_code   <= CODE_ZERO;
      output_update <= 1'b0;
    end else begin
      output_update <= load_now;
      if (in_reset) begin
        output_code <= mid_s ? CODE_MIDSCALE : CODE_ZERO;
      end else if (load_now) begin
        output_code <= input_code;
      end
    end
  end

  // Asynchronous reset drives busy too, so the wire is low the whole time.
  assign link.busy_dev_oe = own_busy | ~resetn;

endmodule : dac_device_end

// ===== dac_host_end.sv
// Host end: sends 24-bit frames, reads back data, drives load and may hold busy.
`timescale 1ns/10ps
module dac_host_end
  import dac_link_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        start,
  input  wire logic [23:0] frame_word,
  input  wire logic        abort,
  input  wire logic        load_request,
  input  wire logic        hold_busy,
  dac_link_if.host         link,
  output logic             start_ready,
  output logic [23:0]      read_word,
  output logic             read_valid,
  output logic             busy_seen
);
  // ==========================================================================
  // Serial clock divider and frame engine
  // ==========================================================================
  host_state_t state;
  logic [7:0]  tick;
  logic [4:0]  bits;
  logic [23:0] shift;
  logic [23:0] rx;
  logic        sclk;
  logic        sel_n;
  logic        load_n;
  logic        dout_s;
  logic        busy_s;

  sync2 #(.INIT(1'b0)) u_dout (.clock(clock), .resetn(resetn), .async_in(link.data_out), .sync_out(dout_s));
  sync2 #(.INIT(1'b1)) u_busy (.clock(clock), .resetn(resetn), .async_in(link.busy_n),   .sync_out(busy_s));

  // Half period suits readback; full speed would be write only.
  wire tick_end = (tick == HALF_CNT - 8'h01);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state      <= host_idle;
      tick       <= '0;
      bits       <= '0;
      shift      <= '0;
      rx         <= '0;
      sclk       <= 1'b0;
      sel_n      <= 1'b1;
      read_word  <= '0;
      read_valid <= 1'b0;
    end else begin
      read_valid <= 1'b0;
      tick       <= tick_end ? 8'h00 : tick + 8'h01;
      unique case (state)
        host_idle: begin
          if (start) begin
            state <= host_high;
            shift <= frame_word;
            bits  <= '0;
            sel_n <= 1'b0;
            tick  <= '0;
          end
        end
        host_high: begin
          if (abort) begin
            state <= host_end;
          end else if (tick_end) begin
            sclk  <= 1'b1;
            state <= host_low;
            // The next bit leaves on the rise, half a period clear of the fall that sampled the last.
            if (bits != 5'h00) begin
              shift <= {shift[22:0], 1'b0};
            end
          end
        end
        host_low: begin
          if (abort) begin
            sclk  <= 1'b0;
            state <= host_end;
          end else if (tick_end) begin
            sclk      <= 1'b0;
            rx        <= {rx[22:0], dout_s};
            bits      <= bits + 5'h01;
            state     <= (bits == LAST_EDGE - 5'h01) ? host_end : host_high;
          end
        end
        host_end: begin
          // Select stays high a further half period so back-to-back frames keep their gap.
          if (tick_end && sel_n) begin
            state      <= host_idle;
          end else if (tick_end) begin
            sel_n      <= 1'b1;
            read_word  <= rx;
            read_valid <= (bits == LAST_EDGE);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      load_n <= 1'b1;
    end else begin
      load_n <= ~load_request;
    end
  end

  assign start_ready        = (state == host_idle);
  assign busy_seen          = ~busy_s;
  assign link.select_n      = sel_n;
  assign link.serial_clock  = sclk;
  assign link.data_in       = shift[23];
  assign link.load_output_n = load_n;
  assign link.busy_host_oe  = hold_busy;

endmodule : dac_host_end

// ===== dac_link_monitor.sv
// Concurrent checks on the link and busy wire between the two ends.
`timescale 1ns/10ps
module dac_link_monitor (
  input wire logic clock,
  input wire logic resetn,
  input wire logic select_n,
  input wire logic serial_clock,
  input wire logic data_out,
  input wire logic data_out_en,
  input wire logic ready_n,
  input wire logic load_output_n,
  input wire logic busy_dev_oe,
  input wire logic busy_n
);
  // ==========================================================================
  // Falling serial clock edges within the current frame
  // ==========================================================================
  logic       sclk_prev;
  logic [4:0] edges;
  wire        sclk_fall  = sclk_prev & ~serial_clock & ~select_n;
  wire        last_fall  = sclk_fall & (edges == 5'h17);
  wire  [4:0] next_edges = select_n ? 5'h0 : (sclk_fall ? edges + 5'h1 : edges);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_prev <= 1'b0;
      edges     <= 5'h0;
    end else begin
      sclk_prev <= serial_clock;
      edges     <= next_edges;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  a_busy_at_release: assert property ($rose(resetn) |-> busy_dev_oe)
    else $error("busy not held at reset release");
  a_ready_on_last: assert property (last_fall |-> ##[1:6] !ready_n)
    else $error("ready missing after last edge");
  a_ready_not_early: assert property ($fell(ready_n) |-> edges == 5'h18)
    else $error("ready before full frame");
  a_ready_release: assert property ($rose(select_n) |-> ##[1:6] ready_n)
    else $error("ready not released");
  a_busy_after_frame: assert property (last_fall |-> ##[1:6] busy_dev_oe)
    else $error("busy not pulled after frame");
  a_out_enable: assert property ($fell(select_n) |-> ##[0:4] data_out_en)
    else $error("data out not enabled");
  a_out_done_off: assert property (last_fall |-> ##[1:6] !data_out_en)
    else $error("data out not released after frame");
  a_abort_off: assert property ($rose(select_n) |-> ##[1:6] !data_out_en)
    else $error("data out not released on select rise");
  a_out_moves_high: assert property ((data_out_en && $past(data_out_en) && $changed(data_out)) |-> serial_clock)
    else $error("data out changed while serial clock low");

  c_full_frame: cover property (last_fall);
  c_abort: cover property ($rose(select_n) && edges != 5'h18 && edges != 5'h0);
  c_load_busy: cover property (!busy_n && !load_output_n);
endmodule : dac_link_monitor

// ===== tb_top.sv
// Self-checking bench joining the host and converter ends over the link.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITF(c) for (int n = 0; !(c); n++) begin if (n > 3000) begin fails++; results(); end step(); end
module tb_top;
  import dac_link_pkg::*;
  logic        clock, resetn, host_resetn, reset_level_mid, soft_reset, start, abort, load_request, hold_busy;
  logic [23:0] frame_word, read_word, rd_word, m_rb;
  logic [15:0] output_code, input_code, m_input, m_output;
  logic        output_update, start_ready, read_valid, busy_seen;
  logic [31:0] seed = 32'hba4b_4602;
  int          fails, samples_checked, ups, u;

  dac_link_if link ();
  dac_device_end u_dac_device_end (.clock(clock), .resetn(resetn), .reset_level_mid(reset_level_mid),
    .soft_reset(soft_reset), .link(link), .output_code(output_code), .input_code(input_code),
    .output_update(output_update));
  dac_host_end u_dac_host_end (.clock(clock), .resetn(host_resetn), .start(start), .frame_word(frame_word),
    .abort(abort), .load_request(load_request), .hold_busy(hold_busy), .link(link), .start_ready(start_ready),
    .read_word(read_word), .read_valid(read_valid), .busy_seen(busy_seen));
  dac_link_monitor u_dac_link_monitor (.clock(clock), .resetn(resetn), .select_n(link.select_n),
    .serial_clock(link.serial_clock), .data_out(link.data_out), .data_out_en(link.data_out_en),
    .ready_n(link.ready_n), .load_output_n(link.load_output_n), .busy_dev_oe(link.busy_dev_oe),
    .busy_n(link.busy_n));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    if (output_update === 1'b1) ups++;
  end

  // Readback word of the last full frame.
  always @(posedge clock) begin
    if (read_valid === 1'b1) rd_word = read_word;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
  endfunction : lfsr

  task step;
    @(posedge clock);
    #1;
  endtask : step

  task results;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // A load strobe held during reset must leave no trace once reset lifts. The host end stays
  // out of reset after the first call, so in the second its strobe really reaches the converter.
  task rst(input logic lvl);
    resetn = 1'b0;
    reset_level_mid = lvl;
    load_request = 1'b1;
    repeat (2) step();
    load_request = 1'b0;
    resetn = 1'b1;
    host_resetn = 1'b1;
    ups = 0;
    repeat (6) step();
    `CHK(ups, 0)
    m_output = lvl ? CODE_MIDSCALE : CODE_ZERO;
    `CHK(output_code, m_output)
    soft_reset = 1'b1;
    repeat (3) step();
    `CHK(link.busy_n, 1'b0)
    soft_reset = 1'b0;
    repeat (8) step();
    `CHK(output_code, m_output)
  endtask : rst

  // Readback returns the converter register, then its upper byte again for the last eight clocks.
  task send(input logic [23:0] w);
    `WAITF(start_ready === 1'b1)
    `CHK(link.ready_n, 1'b1)
    `CHK(rd_word, m_rb)
    m_rb = {m_output, m_output[15:8]};
    start = 1'b1;
    frame_word = w;
    step();
    start = 1'b0;
    `WAITF(link.ready_n === 1'b0)
    repeat (2) step();
    m_input = w[15:0];
    `CHK(input_code, m_input)
    `CHK(output_code, m_output)
  endtask : send

  initial begin
    resetn = 1'b0;
    host_resetn = 1'b0;
    {rd_word, m_rb} = 48'h0000_0000_0000;
    {reset_level_mid, soft_reset, start, abort, load_request, hold_busy} = 6'h00;
    frame_word = 24'h00_0000;
    rst(1'b1);
    rst(1'b0);
    // Pass 0 loads when idle, pass 1 inside own busy, pass 2 under an outside hold.
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      send(seed[23:0]);
      if (i == 0) `WAITF(link.busy_n === 1'b1)
      if (i == 2) begin
        hold_busy = 1'b1;
        repeat (40) step();
      end
      u = ups;
      load_request = 1'b1;
      repeat (6) step();
      load_request = 1'b0;
      if (i > 0) `CHK(output_code, m_output)
      if (i == 2) begin
        repeat (60) step();
        `CHK(ups, u)
        hold_busy = 1'b0;
      end
      `WAITF(ups != u)
      m_output = m_input;
      `CHK(output_code, m_output)
    end
    seed = lfsr(seed);
    `WAITF(start_ready === 1'b1)
    start = 1'b1;
    frame_word = seed[23:0];
    step();
    start = 1'b0;
    repeat (200) step();
    abort = 1'b1;
    `WAITF(link.select_n === 1'b1)
    repeat (20) step();
    abort = 1'b0;
    `CHK(input_code, m_input)
    `CHK(link.data_out_en, 1'b0)
    `CHK(link.ready_n, 1'b1)
    `CHK(rd_word, m_rb)
    results();
  end
endmodule : tb_top
